// ---- design/dam_core.sv ----
/*
 * Data memory addressing: pointers, indirect ports, extended direct
 * addressing, general purpose RAM of all sectors and the accumulator.
 * Assumes the instruction logic issues at most one command per cycle
 * and supplies ALU results; every other special register lives outside.
 */
`timescale 1ns/1ns
`include "dam_map.svh"

module dam_core
    import dam_pkg::*;
#(
    parameter int SECTORS = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command from instruction execution
    input wire logic reqValid,
    input wire dam_cmd_t reqCmd,
    input wire logic reqExt,
    input wire logic [10:0] reqAddr,
    // ALU result
    input wire logic [7:0] aluResult,
    // Answers
    output logic [7:0] readData,
    output logic readValid,
    output logic [7:0] acc
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    generate
        if (SECTORS < 1 || SECTORS > 8) begin : g_bad
            $error("SECTORS must lie between 1 and 8");
        end
    endgenerate

    localparam int RAM_WORDS = SECTORS * 128;

    dam_state_t s;
    dam_state_t next_s;
    logic [7:0] ram [RAM_WORDS];

    // ------------------------------------------------------------------
    // Address resolution
    // ------------------------------------------------------------------
    logic [7:0] dirSector;
    logic [7:0] dirLow;
    logic [1:0] portSel;
    logic [7:0] effSector;
    logic [7:0] effLow;
    logic effInRange;
    logic effGp;
    logic effSfr0;
    logic [9:0] ramIndex;
    logic [7:0] memValue;
    logic [7:0] writeData;
    logic doWrite;

    // Standard accesses sit in sector 0, extended ones carry the sector
    assign dirSector = reqExt ? {5'h00, reqAddr[10:8]} : 8'h00;
    assign dirLow = reqAddr[7:0];

    // Which indirect port, if any, the direct address names
    always_comb begin
        portSel = 2'h0;
        if (dirSector == 8'h00) begin
            if (dirLow == `DAM_ADDR_PORT_FIRST) portSel = 2'h1;
            if (dirLow == `DAM_ADDR_PORT_SECOND) portSel = 2'h2;
            if (dirLow == `DAM_ADDR_PORT_THIRD) portSel = 2'h3;
        end
    end

    // Swap the port address for the location held in its pointers
    always_comb begin
        case (portSel)
            2'h1: begin
                effSector = 8'h00;
                effLow = s.sector0Pointer;
            end
            2'h2: begin
                effSector = s.secondPointerSector;
                effLow = s.secondPointerLow;
            end
            2'h3: begin
                effSector = s.thirdPointerSector;
                effLow = s.thirdPointerLow;
            end
            default: begin
                effSector = dirSector;
                effLow = dirLow;
            end
        endcase
    end

    assign effInRange = effSector < 8'(SECTORS);
    assign effGp = effLow[`DAM_GP_BIT] && effInRange;
    assign effSfr0 = !effLow[`DAM_GP_BIT] && effSector == 8'h00;
    assign ramIndex = 10'({effSector[`DAM_SECTOR_BITS-1:0], effLow[6:0]});

    // Read value; ports and unused special locations answer zero
    always_comb begin
        memValue = `DAM_READ_UNUSED;
        if (effGp) begin
            memValue = ram[ramIndex];
        end else if (effSfr0) begin
            case (effLow)
                `DAM_ADDR_PTR0: memValue = s.sector0Pointer;
                `DAM_ADDR_PTR1_LOW: memValue = s.secondPointerLow;
                `DAM_ADDR_PTR1_SEC: memValue = s.secondPointerSector;
                `DAM_ADDR_PTR2_LOW: memValue = s.thirdPointerLow;
                `DAM_ADDR_PTR2_SEC: memValue = s.thirdPointerSector;
                `DAM_ADDR_ACC: memValue = s.acc;
                default: memValue = `DAM_READ_UNUSED;
            endcase
        end
    end

    // Only the accumulator or the ALU can supply data to memory
    assign writeData = (reqCmd == DAM_CMD_ALU_MEM) ? aluResult : s.acc;
    assign doWrite = reqValid && (reqCmd == DAM_CMD_STORE || reqCmd == DAM_CMD_ALU_MEM);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.readValid = 1'b0;
        if (reqValid) begin
            if (reqCmd == DAM_CMD_READ || reqCmd == DAM_CMD_LOAD) begin
                next_s.readData = memValue;
                next_s.readValid = 1'b1;
            end
            if (reqCmd == DAM_CMD_LOAD) next_s.acc = memValue;
            if (reqCmd == DAM_CMD_ALU_ACC) next_s.acc = aluResult;
        end
        // Writes to a port with no pointer behind it fall through to nothing
        if (doWrite && effSfr0) begin
            case (effLow)
                `DAM_ADDR_PTR0: next_s.sector0Pointer = writeData;
                `DAM_ADDR_PTR1_LOW: next_s.secondPointerLow = writeData;
                `DAM_ADDR_PTR1_SEC: next_s.secondPointerSector = writeData;
                `DAM_ADDR_PTR2_LOW: next_s.thirdPointerLow = writeData;
                `DAM_ADDR_PTR2_SEC: next_s.thirdPointerSector = writeData;
                `DAM_ADDR_ACC: next_s.acc = writeData;
                default: next_s.acc = next_s.acc;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '{acc: `DAM_ACC_RST, sector0Pointer: `DAM_PTR_RST,
                   secondPointerLow: `DAM_PTR_RST, secondPointerSector: `DAM_PTR_RST,
                   thirdPointerLow: `DAM_PTR_RST, thirdPointerSector: `DAM_PTR_RST,
                   readData: 8'h00, readValid: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // General purpose RAM, not cleared by reset
    always_ff @(posedge clk) begin
        if (rst_n && doWrite && effGp) begin
            ram[ramIndex] <= writeData;
        end
    end

    assign readData = s.readData;
    assign readValid = s.readValid;
    assign acc = s.acc;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic isRead;
    assign isRead = reqValid && (reqCmd == DAM_CMD_READ || reqCmd == DAM_CMD_LOAD);

    property p_port_redirect;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && portSel == 2'h2) |-> (effLow == s.secondPointerLow);
    endproperty
    a_port_redirect: assert property (p_port_redirect) else $error("port not redirected");

    property p_first_sector0;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && portSel == 2'h1) |-> (effSector == 8'h00 && effLow == s.sector0Pointer);
    endproperty
    a_first_sector0: assert property (p_first_sector0) else $error("first port left sector 0");

    property p_third_sector;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && portSel == 2'h3) |-> (effSector == s.thirdPointerSector);
    endproperty
    a_third_sector: assert property (p_third_sector) else $error("third port sector wrong");

    property p_port_direct_zero;
        @(posedge clk) disable iff (!rst_n)
        (isRead && portSel != 2'h0 && effSfr0 && (effLow == `DAM_ADDR_PORT_FIRST
            || effLow == `DAM_ADDR_PORT_SECOND || effLow == `DAM_ADDR_PORT_THIRD))
        |=> (readValid && readData == 8'h00);
    endproperty
    a_port_direct_zero: assert property (p_port_direct_zero) else $error("port read not 00H");

    property p_ptr_store;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqCmd == DAM_CMD_STORE && !reqExt && reqAddr[7:0] == `DAM_ADDR_PTR0)
        |=> (s.sector0Pointer == $past(s.acc));
    endproperty
    a_ptr_store: assert property (p_ptr_store) else $error("pointer not stored");

    property p_ext_direct;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqExt && portSel == 2'h0)
        |-> (effSector == {5'h00, reqAddr[10:8]} && effLow == reqAddr[7:0]);
    endproperty
    a_ext_direct: assert property (p_ext_direct) else $error("extended address wrong");

    property p_unused_zero;
        @(posedge clk) disable iff (!rst_n)
        (isRead && reqExt && reqAddr[10:8] != 3'h0 && !reqAddr[7])
        |=> (readValid && readData == 8'h00);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused read not 00H");

    property p_alu_acc;
        @(posedge clk) disable iff (!rst_n)
        (reqValid && reqCmd == DAM_CMD_ALU_ACC) |=> (acc == $past(aluResult));
    endproperty
    a_alu_acc: assert property (p_alu_acc) else $error("ALU result not in accumulator");

    property p_acc_stable;
        @(posedge clk) disable iff (!rst_n)
        !(reqValid && reqCmd != DAM_CMD_READ && reqCmd != DAM_CMD_NONE) |=> $stable(acc);
    endproperty
    a_acc_stable: assert property (p_acc_stable) else $error("accumulator changed");

    property p_read_answer;
        @(posedge clk) disable iff (!rst_n)
        isRead |=> readValid ##1 !readValid || $past(isRead);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer missing");

    c_indirect_store: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && reqCmd == DAM_CMD_STORE && portSel == 2'h2 && effGp);
    c_ext_load: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && reqCmd == DAM_CMD_LOAD && reqExt && effGp);
    c_alu_mem: cover property (@(posedge clk) disable iff (!rst_n)
        reqValid && reqCmd == DAM_CMD_ALU_MEM && portSel == 2'h1);

endmodule

// ---- include/dam_map.svh ----
/*
 * Address map and reset values of the data memory addressing block.
 * Assumes inclusion by bare name from files that need the constants.
 */
`ifndef DAM_MAP_SVH
`define DAM_MAP_SVH

// ----------------------------------------------------------------------
// Sector 0 special function locations
// ----------------------------------------------------------------------
`define DAM_ADDR_PORT_FIRST 8'h00
`define DAM_ADDR_PTR0 8'h01
`define DAM_ADDR_PORT_SECOND 8'h02
`define DAM_ADDR_PTR1_LOW 8'h03
`define DAM_ADDR_PTR1_SEC 8'h04
`define DAM_ADDR_ACC 8'h05
`define DAM_ADDR_PORT_THIRD 8'h0C
`define DAM_ADDR_PTR2_LOW 8'h0D
`define DAM_ADDR_PTR2_SEC 8'h0E

// ----------------------------------------------------------------------
// Layout and values
// ----------------------------------------------------------------------
`define DAM_GP_BIT 7
`define DAM_READ_UNUSED 8'h00
`define DAM_PTR_RST 8'h00
`define DAM_ACC_RST 8'h00
`define DAM_SECTOR_BITS 3

`endif

// ---- include/dam_pkg.sv ----
/*
 * Types of the data memory addressing block: commands and state record.
 * Assumes dam_map.svh is reachable on the include path.
 */
package dam_pkg;

    // ------------------------------------------------------------------
    // Commands issued by the instruction execution logic
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DAM_CMD_NONE,
        DAM_CMD_READ,
        DAM_CMD_LOAD,
        DAM_CMD_STORE,
        DAM_CMD_ALU_ACC,
        DAM_CMD_ALU_MEM
    } dam_cmd_t;

    // ------------------------------------------------------------------
    // Whole register state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] sector0Pointer;
        logic [7:0] secondPointerLow;
        logic [7:0] secondPointerSector;
        logic [7:0] thirdPointerLow;
        logic [7:0] thirdPointerSector;
        logic [7:0] readData;
        logic readValid;
    } dam_state_t;

endpackage

// ---- verif/dam_cpu_model.sv ----
/*
 * Model of the instruction execution logic that issues commands to the
 * data memory addressing block.
 * Assumes one clock and that the bench calls its tasks in sequence.
 */
`timescale 1ns/1ns

module dam_cpu_model
    import dam_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command towards the block
    output logic reqValid,
    output dam_cmd_t reqCmd,
    output logic reqExt,
    output logic [10:0] reqAddr,
    output logic [7:0] aluResult
);
    // ------------------------------------------------------------------
    // Command driving
    // ------------------------------------------------------------------
    // Quiet bus at time zero
    initial begin
        reqValid = 1'b0;
        reqCmd = DAM_CMD_NONE;
        reqExt = 1'b0;
        reqAddr = 11'h000;
        aluResult = 8'h00;
    end

    // One command, launched just after an edge and taken at the next
    task automatic issue(input dam_cmd_t cmd, input logic ext, input logic [10:0] addr,
                         input logic [7:0] alu);
        @(posedge clk);
        reqValid <= 1'b1;
        reqCmd <= cmd;
        reqExt <= ext;
        reqAddr <= addr;
        aluResult <= alu;
    endtask

    // Released bus: stale address and ALU fields keep toggling so they are never trusted
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            reqValid <= 1'b0;
            reqCmd <= DAM_CMD_NONE;
            reqAddr <= ~reqAddr;
            aluResult <= ~aluResult;
        end
    endtask
endmodule

// ---- verif/test_indirect_data_addressing.sv ----
/*
 * Self-checking bench of the data memory addressing block.
 * Assumes the package, map header and design are compiled first.
 */
`timescale 1ns/1ns

module test_indirect_data_addressing
    import dam_pkg::*;
;
    logic clk;
    logic rst_n;
    logic reqValid;
    dam_cmd_t reqCmd;
    logic reqExt;
    logic [10:0] reqAddr;
    logic [7:0] aluResult;
    logic [7:0] readData;
    logic readValid;
    logic [7:0] acc;
    int numErrors = 0;
    int checks = 0;

    // ------------------------------------------------------------------
    // Clock, reset and instances
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #25 clk = ~clk;

    dam_cpu_model cpu (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqCmd(reqCmd),
        .reqExt(reqExt), .reqAddr(reqAddr), .aluResult(aluResult));

    dam_core #(.SECTORS(8)) dut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
        .reqCmd(reqCmd), .reqExt(reqExt), .reqAddr(reqAddr), .aluResult(aluResult),
        .readData(readData), .readValid(readValid), .acc(acc));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Byte comparison with counting
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write through the accumulator, the only path into memory beside the ALU result
    task automatic wr(input logic ext, input logic [10:0] addr, input logic [7:0] val);
        cpu.issue(DAM_CMD_ALU_ACC, 1'b0, 11'h000, val);
        cpu.issue(DAM_CMD_STORE, ext, addr, 8'h00);
    endtask

    // Load, then judge the one-cycle answer and the accumulator copy
    task automatic rd(input logic ext, input logic [10:0] addr, input logic [7:0] exp);
        cpu.issue(DAM_CMD_LOAD, ext, addr, 8'h00);
        cpu.idle(1);
        #1;
        chk({7'h00, readValid}, 8'h01);
        chk(readData, exp);
        chk(acc, exp);
    endtask

    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values of the accumulator, answer flag and all five pointers
    task automatic testReset();
        logic [10:0] ptrs [5] = '{11'h001, 11'h003, 11'h004, 11'h00D, 11'h00E};
        chk(acc, 8'h00);
        chk({7'h00, readValid}, 8'h00);
        foreach (ptrs[i]) rd(1'b0, ptrs[i], 8'h00);
        $display("test reset done");
    endtask

    // First port through its pointer, pointer increment without acc
    task automatic testFirstPort();
        wr(1'b0, 11'h001, 8'h85);
        wr(1'b0, 11'h000, 8'h3C);
        rd(1'b0, 11'h085, 8'h3C);
        rd(1'b0, 11'h000, 8'h3C);
        cpu.issue(DAM_CMD_ALU_MEM, 1'b0, 11'h001, 8'h86);
        cpu.idle(1);
        #1;
        chk(acc, 8'h3C);
        rd(1'b0, 11'h001, 8'h86);
        wr(1'b1, 11'h186, 8'h11);
        wr(1'b0, 11'h000, 8'hC7);
        rd(1'b0, 11'h086, 8'hC7);
        rd(1'b1, 11'h186, 8'h11);
        cpu.issue(DAM_CMD_ALU_MEM, 1'b0, 11'h000, 8'h4D);
        rd(1'b0, 11'h086, 8'h4D);
        $display("test first port done");
    endtask

    // Second and third ports select a sector by their high byte
    task automatic testSectorPorts();
        wr(1'b0, 11'h003, 8'hF0);
        wr(1'b0, 11'h004, 8'h01);
        wr(1'b0, 11'h002, 8'h5A);
        rd(1'b1, 11'h1F0, 8'h5A);
        wr(1'b0, 11'h00D, 8'hF0);
        wr(1'b0, 11'h00E, 8'h07);
        wr(1'b1, 11'h7F0, 8'hC3);
        rd(1'b0, 11'h00C, 8'hC3);
        wr(1'b0, 11'h0F0, 8'h99);
        rd(1'b0, 11'h7F0, 8'h99);
        rd(1'b0, 11'h002, 8'h5A);
        $display("test sector ports done");
    endtask

    // Pointer aimed at a port: reads zero, writes change nothing
    task automatic testPortDirect();
        wr(1'b0, 11'h001, 8'h02);
        wr(1'b0, 11'h000, 8'hAA);
        rd(1'b0, 11'h000, 8'h00);
        rd(1'b0, 11'h002, 8'h5A);
        wr(1'b0, 11'h001, 8'h00);
        wr(1'b0, 11'h000, 8'hBB);
        rd(1'b0, 11'h000, 8'h00);
        $display("test port direct done");
    endtask

    // Unused special places and RAM bounds of every sector
    task automatic testMap();
        wr(1'b0, 11'h040, 8'h77);
        rd(1'b0, 11'h040, 8'h00);
        wr(1'b1, 11'h140, 8'h66);
        rd(1'b1, 11'h140, 8'h00);
        for (int s = 0; s < 8; s++) begin
            wr(1'b1, {s[2:0], 8'h80}, 8'h20 + 8'(s));
            wr(1'b1, {s[2:0], 8'hFF}, 8'h40 + 8'(s));
        end
        for (int s = 0; s < 8; s++) begin
            rd(1'b1, {s[2:0], 8'h80}, 8'h20 + 8'(s));
            rd(1'b1, {s[2:0], 8'hFF}, 8'h40 + 8'(s));
        end
        $display("test map done");
    endtask

    // Accumulator takes the ALU result and is visible in the map
    task automatic testAcc();
        cpu.issue(DAM_CMD_ALU_ACC, 1'b0, 11'h000, 8'hE1);
        cpu.idle(1);
        #1;
        chk(acc, 8'hE1);
        rd(1'b0, 11'h005, 8'hE1);
        cpu.issue(DAM_CMD_READ, 1'b1, 11'h7F0, 8'h00);
        cpu.idle(1);
        #1;
        chk({7'h00, readValid}, 8'h01);
        chk(readData, 8'hC3);
        chk(acc, 8'hE1);
        $display("test accumulator done");
    endtask

    // Reset in mid-run clears the sector 0 pointer and accumulator but keeps RAM
    task automatic testMidReset();
        wr(1'b0, 11'h001, 8'h90);
        wr(1'b0, 11'h000, 8'h5E);
        cpu.idle(1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk(acc, 8'h00);
        chk({7'h00, readValid}, 8'h00);
        rd(1'b0, 11'h001, 8'h00);
        rd(1'b0, 11'h090, 8'h5E);
        $display("test mid-run reset done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
        testFirstPort();
        testSectorPorts();
        testPortDirect();
        testMap();
        testAcc();
        testMidReset();
        cpu.idle(2);
        giveVerdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        $display("timeout at %0t", $time);
        giveVerdict();
    end
endmodule
